// ### mac_adapter_pkg.sv
// Shared types and constants for the MAC stream adapter
package mac_adapter_pkg;

   // ----------------------------------------------------------------
   // Data path widths
   // ----------------------------------------------------------------
   localparam int WIDE_W = 128;
   localparam int BEAT_W = 64;
   localparam int WIDE_KEEP_W = WIDE_W / 8;
   localparam int BEAT_KEEP_W = BEAT_W / 8;

   // ----------------------------------------------------------------
   // Address filter
   // ----------------------------------------------------------------
   localparam int ADDR_W = 48;
   localparam logic [47:0] BROADCAST_ADDR = 48'hFFFFFFFFFFFF;

   // ----------------------------------------------------------------
   // Receive statistics vector and frame size limits
   // ----------------------------------------------------------------
   localparam int STATS_W = 30;
   localparam int STATS_LEN_LSB = 5;
   localparam int STATS_LEN_W = 14;
   localparam int MAX_FRAME_BYTES = 16383;
   // One longest frame plus the same again as slack for downstream stalls
   localparam int RX_FIFO_DEPTH = 2 * 2048;
   localparam int OUT_FIFO_DEPTH = 16;
   localparam int COUNT_W = 16;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDE_W-1:0] data;
      logic [WIDE_KEEP_W-1:0] keep;
      logic last;
   } wide_word_t;

   typedef struct packed {
      logic [BEAT_W-1:0] data;
      logic [BEAT_KEEP_W-1:0] keep;
      logic last;
   } beat_t;

endpackage

// ### mac_stream_adapter.sv
// Transmit narrowing, receive filtering, frame buffering and widening

// ----------------------------------------------------------------
// Frame FIFO with commit and discard of the write side
// ----------------------------------------------------------------
module frame_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   input wire logic i_commit,
   input wire logic i_discard,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic o_empty
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_tmp, wr_com, rd_ptr;
   logic [AW:0] next_wr_tmp, next_wr_com, next_rd_ptr;
   logic next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic push, load;

   // Occupancy counts uncommitted words too, so a frame in flight holds room
   assign o_in_ready = (wr_tmp - rd_ptr) != (AW + 1)'(DEPTH);
   assign o_empty = (wr_com == rd_ptr) && !o_out_valid;
   assign push = i_in_valid && o_in_ready && !i_discard;
   assign load = (wr_com != rd_ptr) && (!o_out_valid || i_out_ready);

   // Pointer and output stage next values
   always_comb begin
      next_wr_tmp = push ? wr_tmp + 1'b1 : wr_tmp;
      if (i_discard) begin
         next_wr_tmp = wr_com;
      end
      next_wr_com = i_commit ? next_wr_tmp : wr_com;
      next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
      next_out_valid = o_out_valid;
      next_out_data = o_out_data;
      if (load) begin
         next_out_valid = 1'b1;
         next_out_data = mem[rd_ptr[AW-1:0]];
      end else if (i_out_ready) begin
         next_out_valid = 1'b0;
      end
   end

   // Output is a register stage so readers see flip-flop data
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         wr_tmp <= '0;
         wr_com <= '0;
         rd_ptr <= '0;
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else begin
         wr_tmp <= next_wr_tmp;
         wr_com <= next_wr_com;
         rd_ptr <= next_rd_ptr;
         o_out_valid <= next_out_valid;
         o_out_data <= next_out_data;
      end
   end

   // Storage write
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_tmp[AW-1:0]] <= i_in_data;
      end
   end
endmodule

// ----------------------------------------------------------------
// Adapter top
// ----------------------------------------------------------------
module mac_stream_adapter #(
   parameter int RX_DEPTH = mac_adapter_pkg::RX_FIFO_DEPTH,
   parameter int OUT_DEPTH = mac_adapter_pkg::OUT_FIFO_DEPTH,
   parameter int CNT_W = mac_adapter_pkg::COUNT_W
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   // Packet buffer read side
   input wire mac_adapter_pkg::wide_word_t i_pb_word,
   input wire logic [CNT_W-1:0] i_pb_rd_count,
   input wire logic [CNT_W-1:0] i_pb_head_words,
   output logic o_pb_ready,
   // MAC transmit stream
   output mac_adapter_pkg::beat_t o_mtx_beat,
   output logic o_mtx_tvalid,
   input wire logic i_mtx_tready,
   // MAC receive stream and statistics
   input wire mac_adapter_pkg::beat_t i_mrx_beat,
   input wire logic i_mrx_tvalid,
   input wire logic i_mrx_tuser,
   input wire logic [mac_adapter_pkg::STATS_W-1:0] i_rx_stats_vec,
   input wire logic i_rx_stats_valid,
   // Filter control
   input wire logic i_filter_en,
   input wire logic i_promisc,
   input wire logic [mac_adapter_pkg::ADDR_W-1:0] i_station_addr,
   // Virtual FIFO write side
   output mac_adapter_pkg::wide_word_t o_vf_word,
   output logic o_vf_tvalid,
   input wire logic i_vf_tready,
   output logic [mac_adapter_pkg::STATS_LEN_W-1:0] o_rx_len
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Low half is last only when the upper lanes carry nothing
   function automatic mac_adapter_pkg::beat_t half_of(mac_adapter_pkg::wide_word_t w, logic hi);
      mac_adapter_pkg::beat_t b;
      if (hi) begin
         b.data = w.data[127:64];
         b.keep = w.keep[15:8];
         b.last = w.last;
      end else begin
         b.data = w.data[63:0];
         b.keep = w.keep[7:0];
         b.last = w.last && (w.keep[15:8] == 8'h00);
      end
      return b;
   endfunction

   function automatic logic addr_pass(logic [47:0] da, logic en, logic promisc, logic [47:0] station);
      return !en || promisc || (da == station) ||
         (da == mac_adapter_pkg::BROADCAST_ADDR);
   endfunction

   // ----------------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_LO, TX_HI} tx_state_t;
   tx_state_t tx_state, next_tx_state;
   mac_adapter_pkg::wide_word_t word, next_word;
   mac_adapter_pkg::beat_t next_mtx_beat;
   logic next_pb_ready, next_mtx_tvalid;
   logic pkt_stored;

   // Whole packet present, so later pops cannot find the buffer empty
   assign pkt_stored = (i_pb_head_words != '0) && (i_pb_rd_count >= i_pb_head_words);

   // Transmit sequencing
   always_comb begin
      next_tx_state = tx_state;
      next_pb_ready = 1'b0;
      next_word = o_pb_ready ? i_pb_word : word;
      next_mtx_beat = o_mtx_beat;
      next_mtx_tvalid = o_mtx_tvalid;
      case (tx_state)
         TX_IDLE: begin
            if (pkt_stored) begin
               next_pb_ready = 1'b1;
               next_tx_state = TX_FIRST;
            end
         end
         TX_FIRST: begin
            next_mtx_beat = half_of(i_pb_word, 1'b0);
            next_mtx_tvalid = 1'b1;
            next_tx_state = TX_LO;
         end
         TX_LO: begin
            if (i_mtx_tready) begin
               if (o_mtx_beat.last) begin
                  next_mtx_tvalid = 1'b0;
                  next_tx_state = TX_IDLE;
               end else begin
                  next_mtx_beat = half_of(word, 1'b1);
                  // Prefetch the next word while the upper half goes out
                  next_pb_ready = !word.last;
                  next_tx_state = TX_HI;
               end
            end
         end
         TX_HI: begin
            if (i_mtx_tready) begin
               if (o_mtx_beat.last) begin
                  next_mtx_tvalid = 1'b0;
                  next_tx_state = TX_IDLE;
               end else begin
                  // Valid never drops mid packet: next word is already held
                  next_mtx_beat = half_of(next_word, 1'b0);
                  next_tx_state = TX_LO;
               end
            end
         end
         default: begin
            next_tx_state = TX_IDLE;
            next_mtx_tvalid = 1'b0;
         end
      endcase
   end

   // Transmit registers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         tx_state <= TX_IDLE;
         word <= '0;
         o_pb_ready <= 1'b0;
         o_mtx_beat <= '0;
         o_mtx_tvalid <= 1'b0;
      end else begin
         tx_state <= next_tx_state;
         word <= next_word;
         o_pb_ready <= next_pb_ready;
         o_mtx_beat <= next_mtx_beat;
         o_mtx_tvalid <= next_mtx_tvalid;
      end
   end

   // ----------------------------------------------------------------
   // Receive filtering and frame admission
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {RX_IDLE, RX_KEEP, RX_DROP} rx_state_t;
   rx_state_t rx_state, next_rx_state;
   logic rxf_in_ready, rxf_wr, rxf_commit, rxf_discard, rxf_pop_ready;
   logic frame_ok, next_frame_ok;
   logic [mac_adapter_pkg::STATS_LEN_W-1:0] next_rx_len;
   mac_adapter_pkg::beat_t rxf_out;
   logic rxf_out_valid;

   // The MAC cannot be stalled, so no ready goes back; beats are kept or lost
   always_comb begin
      next_rx_state = rx_state;
      next_frame_ok = frame_ok;
      rxf_wr = 1'b0;
      rxf_commit = 1'b0;
      rxf_discard = 1'b0;
      next_rx_len = o_rx_len;
      if (i_rx_stats_valid && frame_ok) begin
         next_rx_len = i_rx_stats_vec[mac_adapter_pkg::STATS_LEN_LSB +: mac_adapter_pkg::STATS_LEN_W];
      end
      if (i_mrx_tvalid) begin
         case (rx_state)
            RX_IDLE: begin
               if (!addr_pass(i_mrx_beat.data[47:0], i_filter_en, i_promisc, i_station_addr)) begin
                  // Mismatch dropped as it arrives, nothing written
                  next_frame_ok = 1'b0;
                  next_rx_state = i_mrx_beat.last ? RX_IDLE : RX_DROP;
               end else if (!rxf_in_ready) begin
                  next_frame_ok = 1'b0;
                  next_rx_state = i_mrx_beat.last ? RX_IDLE : RX_DROP;
               end else begin
                  rxf_wr = 1'b1;
                  if (i_mrx_beat.last) begin
                     rxf_commit = i_mrx_tuser;
                     rxf_discard = !i_mrx_tuser;
                     next_frame_ok = i_mrx_tuser;
                  end else begin
                     next_rx_state = RX_KEEP;
                  end
               end
            end
            RX_KEEP: begin
               if (!rxf_in_ready) begin
                  // Rewind the partial frame and swallow the rest
                  rxf_discard = 1'b1;
                  next_frame_ok = 1'b0;
                  next_rx_state = i_mrx_beat.last ? RX_IDLE : RX_DROP;
               end else begin
                  rxf_wr = 1'b1;
                  if (i_mrx_beat.last) begin
                     rxf_commit = i_mrx_tuser;
                     rxf_discard = !i_mrx_tuser;
                     next_frame_ok = i_mrx_tuser;
                     next_rx_state = RX_IDLE;
                  end
               end
            end
            RX_DROP: begin
               if (i_mrx_beat.last) begin
                  next_rx_state = RX_IDLE;
               end
            end
            default: begin
               next_rx_state = RX_IDLE;
            end
         endcase
      end
   end

   // Receive registers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         rx_state <= RX_IDLE;
         frame_ok <= 1'b0;
         o_rx_len <= '0;
      end else begin
         rx_state <= next_rx_state;
         frame_ok <= next_frame_ok;
         o_rx_len <= next_rx_len;
      end
   end

   // Local frame store sized for a longest frame plus stall slack
   frame_fifo #(
      .WIDTH($bits(mac_adapter_pkg::beat_t)),
      .DEPTH(RX_DEPTH)
   ) rx_store (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(rxf_wr),
      .o_in_ready(rxf_in_ready),
      .i_in_data(i_mrx_beat),
      .i_commit(rxf_commit),
      .i_discard(rxf_discard),
      .o_out_valid(rxf_out_valid),
      .i_out_ready(rxf_pop_ready),
      .o_out_data(rxf_out),
      .o_empty()
   );

   // ----------------------------------------------------------------
   // Receive widening
   // ----------------------------------------------------------------
   logic rxf_pop, have_lo, next_have_lo;
   mac_adapter_pkg::beat_t lo, next_lo;
   mac_adapter_pkg::wide_word_t pair;
   logic pair_valid, out_in_ready;

   // Stalls reading whenever the output buffer is full, so back-pressure
   // from the virtual FIFO reaches the frame store
   assign rxf_pop_ready = out_in_ready;
   assign rxf_pop = rxf_out_valid && rxf_pop_ready;

   // Pair two beats into one word; a lone last beat leaves the top empty
   always_comb begin
      next_have_lo = have_lo;
      next_lo = lo;
      pair_valid = 1'b0;
      pair = '0;
      if (rxf_pop) begin
         if (have_lo) begin
            pair.data = {rxf_out.data, lo.data};
            pair.keep = {rxf_out.keep, lo.keep};
            pair.last = rxf_out.last;
            pair_valid = 1'b1;
            next_have_lo = 1'b0;
         end else if (rxf_out.last) begin
            pair.data = {64'h0000000000000000, rxf_out.data};
            pair.keep = {8'h00, rxf_out.keep};
            pair.last = 1'b1;
            pair_valid = 1'b1;
         end else begin
            next_lo = rxf_out;
            next_have_lo = 1'b1;
         end
      end
   end

   // Widening registers
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         have_lo <= 1'b0;
         lo <= '0;
      end else begin
         have_lo <= next_have_lo;
         lo <= next_lo;
      end
   end

   // Output buffer toward the virtual FIFO
   frame_fifo #(
      .WIDTH($bits(mac_adapter_pkg::wide_word_t)),
      .DEPTH(OUT_DEPTH)
   ) out_buf (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(pair_valid),
      .o_in_ready(out_in_ready),
      .i_in_data(pair),
      .i_commit(1'b1),
      .i_discard(1'b0),
      .o_out_valid(o_vf_tvalid),
      .i_out_ready(i_vf_tready),
      .o_out_data(o_vf_word),
      .o_empty()
   );

endmodule

// ### mac_stream_adapter_chk.sv
// Concurrent checks on the adapter top ports
module mac_stream_adapter_chk #(
   parameter int CNT_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire mac_adapter_pkg::wide_word_t i_pb_word,
   input wire logic [CNT_W-1:0] i_pb_rd_count,
   input wire logic [CNT_W-1:0] i_pb_head_words,
   input wire logic o_pb_ready,
   input wire mac_adapter_pkg::beat_t o_mtx_beat,
   input wire logic o_mtx_tvalid,
   input wire logic i_mtx_tready,
   input wire mac_adapter_pkg::wide_word_t o_vf_word,
   input wire logic o_vf_tvalid,
   input wire logic i_vf_tready
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Transmit side
   // ----------------------------------------------------------------
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   chk_pop_spacing: assert property (o_pb_ready |=> !o_pb_ready)
      else $error("buffer popped on two adjacent cycles");
   chk_start_full: assert property (o_pb_ready && !o_mtx_tvalid |->
      $past(i_pb_head_words) != 0 && $past(i_pb_rd_count) >= $past(i_pb_head_words))
      else $error("packet started before it was fully buffered");
   // Only the unstalled case: a stalled high beat legally delays the next low beat
   chk_pop_low: assert property (o_pb_ready && (!o_mtx_tvalid || i_mtx_tready) |=>
      o_mtx_tvalid && o_mtx_beat.data == $past(i_pb_word.data[63:0]))
      else $error("popped word low half not presented next");
   chk_tx_hold: assert property (o_mtx_tvalid && !i_mtx_tready |=> o_mtx_tvalid && $stable(o_mtx_beat))
      else $error("transmit beat changed while stalled");
   chk_tx_no_gap: assert property (o_mtx_tvalid && !o_mtx_beat.last |=> o_mtx_tvalid)
      else $error("gap inside transmit packet");
   chk_tx_end_idle: assert property (o_mtx_tvalid && i_mtx_tready && o_mtx_beat.last |=> !o_mtx_tvalid)
      else $error("no idle cycle after packet end");

   // ----------------------------------------------------------------
   // Receive side checks, and cover points for both sides
   // ----------------------------------------------------------------
   chk_vf_hold: assert property (o_vf_tvalid && !i_vf_tready |=> o_vf_tvalid && $stable(o_vf_word))
      else $error("output word changed while stalled");
   chk_odd_pad: assert property (o_vf_tvalid && o_vf_word.keep[15:8] == 8'h00 |->
      o_vf_word.last && o_vf_word.data[127:64] == 64'h0)
      else $error("half word not padded or not last");

   cov_tx_end: cover property (o_mtx_tvalid && i_mtx_tready && o_mtx_beat.last);
   cov_tx_stall: cover property (o_mtx_tvalid && !i_mtx_tready);
   cov_vf_end: cover property (o_vf_tvalid && i_vf_tready && o_vf_word.last);
   cov_vf_stall: cover property (o_vf_tvalid && !i_vf_tready);
endmodule

bind mac_stream_adapter mac_stream_adapter_chk #(.CNT_W(CNT_W)) u_mac_stream_adapter_chk (.i_mclk, .i_sys_rst,
   .i_pb_word, .i_pb_rd_count, .i_pb_head_words, .o_pb_ready, .o_mtx_beat, .o_mtx_tvalid, .i_mtx_tready,
   .o_vf_word, .o_vf_tvalid, .i_vf_tready);

// ### mac_far_end.sv
// Behavioural model of the MAC stream ports facing the adapter
module mac_far_end (
   input wire logic i_mclk,
   input wire logic i_slow,
   output logic o_tready,
   output mac_adapter_pkg::beat_t o_beat,
   output logic o_tvalid,
   output logic o_tuser,
   output logic [29:0] o_stats_vec,
   output logic o_stats_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'h88C4;

   initial begin
      o_tready = 1'b1;
      o_beat = '0;
      o_tvalid = 1'b0;
      o_tuser = 1'b0;
      o_stats_vec = '0;
      o_stats_valid = 1'b0;
   end

   // Transmit sink stalls at random when slow, to stress the hold rules
   always @(posedge i_mclk) begin
      o_tready <= i_slow ? ($random(seed) % 3 != 0) : 1'b1;
   end

   // Receive source never pauses inside a frame; idle bus shows the inverse of the last beat
   task automatic send_frame(input mac_adapter_pkg::beat_t q[$], input logic good);
      foreach (q[i]) begin
         @(posedge i_mclk);
         o_beat <= q[i];
         o_tvalid <= 1'b1;
         o_tuser <= q[i].last ? good : ~good;
      end
      @(posedge i_mclk);
      o_tvalid <= 1'b0;
      o_beat <= ~q[q.size()-1];
      o_stats_valid <= 1'b1;
      o_stats_vec <= 30'(q.size() * 8) << mac_adapter_pkg::STATS_LEN_LSB;
      @(posedge i_mclk);
      o_stats_valid <= 1'b0;
   endtask
endmodule

// ### test_mac_stream_adapter.sv
// Self-checking bench for the MAC stream adapter
module test_mac_stream_adapter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RXD = 64;
   localparam logic [47:0] STA = 48'h0A1B2C3D4E5F;
   logic i_mclk = 1'b0, i_sys_rst = 1'b1, o_pb_ready, o_mtx_tvalid, i_mtx_tready, i_mrx_tvalid, i_mrx_tuser;
   logic i_rx_stats_valid, i_filter_en = 1'b0, i_promisc = 1'b0, o_vf_tvalid, i_vf_tready = 1'b0, mac_slow = 1'b0;
   logic [15:0] i_pb_rd_count = '0, i_pb_head_words = '0;
   logic [29:0] i_rx_stats_vec;
   logic [47:0] i_station_addr = STA;
   logic [13:0] o_rx_len, last_len = '0;
   mac_adapter_pkg::wide_word_t i_pb_word = '0, o_vf_word;
   mac_adapter_pkg::beat_t o_mtx_beat, i_mrx_beat;
   mac_adapter_pkg::wide_word_t pb[$], feed[$];
   logic [144:0] exp_tx[$], exp_rx[$];
   int lens[$];
   int popped = 0, cyc = 0, num_errors = 0, n_checks = 0;
   integer seed = 32'h88C4;
   logic vf_stall = 1'b0;

   mac_stream_adapter #(.RX_DEPTH(RXD)) u_mac_stream_adapter (.i_mclk, .i_sys_rst, .i_pb_word, .i_pb_rd_count,
      .i_pb_head_words, .o_pb_ready, .o_mtx_beat, .o_mtx_tvalid, .i_mtx_tready, .i_mrx_beat, .i_mrx_tvalid,
      .i_mrx_tuser, .i_rx_stats_vec, .i_rx_stats_valid, .i_filter_en, .i_promisc, .i_station_addr, .o_vf_word,
      .o_vf_tvalid, .i_vf_tready, .o_rx_len);
   mac_far_end u_mac_far_end (.i_mclk, .i_slow(mac_slow), .o_tready(i_mtx_tready), .o_beat(i_mrx_beat),
      .o_tvalid(i_mrx_tvalid), .o_tuser(i_mrx_tuser), .o_stats_vec(i_rx_stats_vec), .o_stats_valid(i_rx_stats_valid));

   initial forever #2.5 i_mclk = ~i_mclk;

   task automatic check(input string nm, input logic [144:0] e, input logic [144:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Packet buffer model: slow fill, first-word-fall-through head, pop on ready
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (o_pb_ready && pb.size() > 0) begin
         void'(pb.pop_front());
         popped++;
         if (popped == lens[0]) begin
            void'(lens.pop_front());
            popped = 0;
         end
      end
      if (feed.size() > 0 && cyc[1]) pb.push_back(feed.pop_front());
      i_pb_rd_count <= 16'(pb.size());
      i_pb_head_words <= lens.size() > 0 ? 16'(lens[0]) : 16'h0000;
      i_pb_word <= pb.size() > 0 ? pb[0] : ~i_pb_word;
      i_vf_tready <= vf_stall ? 1'b0 : ($random(seed) % 4 != 0);
   end

   // Output watcher: oldest note against each accepted result; also cuts a hang short
   always @(posedge i_mclk) begin
      if (!i_sys_rst && o_mtx_tvalid && i_mtx_tready)
         check("tx_beat", exp_tx.size() > 0 ? exp_tx.pop_front() : 'x, o_mtx_beat);
      if (!i_sys_rst && o_vf_tvalid && i_vf_tready)
         check("vf_word", exp_rx.size() > 0 ? exp_rx.pop_front() : 'x, o_vf_word);
      if (cyc > 40000) begin
         num_errors++;
         give_verdict();
      end
   end

   // Narrow-side expectation: low half first, high half skipped when the last word is half full
   task automatic tx_packet(input int n, input bit half);
      mac_adapter_pkg::wide_word_t w;
      for (int i = 0; i < n; i++) begin
         w = {$random(seed), $random(seed), $random(seed), $random(seed), 16'hFFFF, i == n - 1};
         if (w.last && half) w.keep[15:8] = 8'h00;
         feed.push_back(w);
         exp_tx.push_back({w.data[63:0], w.keep[7:0], w.last && half});
         if (!(w.last && half)) exp_tx.push_back({w.data[127:64], w.keep[15:8], w.last});
      end
      lens.push_back(n);
   endtask

   // Receive expectation worked out from the filter, error and overflow rules
   task automatic rx_frame(input int n, input logic [47:0] da, input bit good);
      mac_adapter_pkg::beat_t q[$];
      mac_adapter_pkg::beat_t b;
      bit kept;
      kept = good && n <= RXD && (!i_filter_en || i_promisc || da == i_station_addr ||
         da == mac_adapter_pkg::BROADCAST_ADDR);
      for (int i = 0; i < n; i++) begin
         b = {$random(seed), $random(seed), 8'hFF, i == n - 1};
         if (i == 0) b.data[47:0] = da;
         q.push_back(b);
         if (kept && i % 2 == 1) exp_rx.push_back({b.data, q[i-1].data, b.keep, q[i-1].keep, b.last});
         else if (kept && b.last) exp_rx.push_back({64'h0, b.data, 8'h00, b.keep, 1'b1});
      end
      if (kept) last_len = 14'(n * 8);
      u_mac_far_end.send_frame(q, good);
   endtask

   task automatic drain();
      for (int k = 0; k < 4000 && (exp_tx.size() > 0 || exp_rx.size() > 0); k++) @(posedge i_mclk);
      repeat (8) @(posedge i_mclk);
   endtask

   initial begin
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      // Transmit: packets of 1 to 3 words, arriving slowly, half-full tails, sink stalling later on
      for (int i = 0; i < 8; i++) begin
         // First half runs against an eager sink, the rest against a stalling one
         if (i == 4) begin
            drain();
            mac_slow <= 1'b1;
         end
         tx_packet(1 + i % 3, i % 2 == 1);
      end
      drain();
      // Receive: filter off, error, match, mismatch, broadcast, promiscuous, bad match, bad mismatch
      for (int i = 0; i < 8; i++) begin
         @(posedge i_mclk);
         i_filter_en <= i > 1;
         i_promisc <= i == 5;
         @(posedge i_mclk);
         rx_frame(i + 2, (i == 2 || i == 6) ? STA : (i == 4) ? 48'hFFFFFFFFFFFF : 48'h0A1B2C3D4E50, i != 1 && i < 6);
         drain();
         check("rx_len", last_len, o_rx_len);
      end
      // Oversized frame dropped whole, next one passes
      rx_frame(RXD + 16, STA, 1'b1);
      rx_frame(5, STA, 1'b1);
      drain();
      // Station address moved: the new one is kept, the old one refused
      i_station_addr <= 48'h0A1B2C3D4E50;
      @(posedge i_mclk);
      rx_frame(3, 48'h0A1B2C3D4E50, 1'b1);
      rx_frame(3, STA, 1'b1);
      drain();
      check("rx_len", last_len, o_rx_len);
      // Output stalled while frames pile up, then released
      vf_stall <= 1'b1;
      for (int i = 0; i < 3; i++) rx_frame(12, 48'hFFFFFFFFFFFF, 1'b1);
      repeat (60) @(posedge i_mclk);
      vf_stall <= 1'b0;
      drain();
      check("queues_left", '0, exp_tx.size() + exp_rx.size());
      give_verdict();
   end
endmodule
